//--- core/ict_pkg.sv
// instruction cycle timing: shared constants and types
// assumes one 100 MHz clock, synchronous active-high reset
package ict_pkg;
    // ---------------------------------------------------------------
    // instruction classes presented by the decoder
    // ---------------------------------------------------------------
    typedef enum logic [4:0] {
        ICT_DP      = 5'h00,
        ICT_DP_RS   = 5'h01,
        ICT_DP_PC   = 5'h02,
        ICT_LDR     = 5'h03,
        ICT_LDR_PC  = 5'h04,
        ICT_STR     = 5'h05,
        ICT_LDM     = 5'h06,
        ICT_LDM_PC  = 5'h07,
        ICT_STM     = 5'h08,
        ICT_BRANCH  = 5'h09,
        ICT_SWI     = 5'h0A,
        ICT_MUL     = 5'h0B,
        ICT_CDP     = 5'h0C,
        ICT_CPLS    = 5'h0D,
        ICT_MCR     = 5'h0E,
        ICT_MRC     = 5'h0F,
        ICT_UNDEF   = 5'h10
    } ict_class_t;

    // bus cycle kinds, encoded as {memory_request_n, sequential_access}
    typedef enum logic [1:0] {
        ICT_CYC_N = 2'h0,
        ICT_CYC_S = 2'h1,
        ICT_CYC_I = 2'h2,
        ICT_CYC_C = 2'h3
    } ict_cyc_t;

    // one-hot sequencer states
    typedef enum logic [6:0] {
        ICT_ST_IDLE  = 7'h01,
        ICT_ST_EXEC  = 7'h02,
        ICT_ST_WAIT  = 7'h04,
        ICT_ST_OFFER = 7'h08,
        ICT_ST_UINT  = 7'h10,
        ICT_ST_VEC0  = 7'h20,
        ICT_ST_VEC1  = 7'h40
    } ict_state_t;

    localparam int ICT_ADDR_W = 26;
    localparam int ICT_DATA_W = 32;
    localparam int ICT_CNT_W = 6;
    localparam int ICT_MUL_MAX = 16;
    localparam logic [ICT_ADDR_W-1:0] ICT_FETCH_AHEAD = 26'h0000008;
    localparam logic [ICT_ADDR_W-1:0] ICT_WORD_STEP = 26'h0000004;
    localparam logic [ICT_ADDR_W-1:0] ICT_RESET_PC = 26'h0000000;
endpackage : ict_pkg

//--- core/ict_mul_len.sv
// multiply length: iteration count m from the multiplier operand
// assumes a purely combinational use inside the sequencer
module ict_mul_len #(
    parameter int MAX_M = 16
) (
    input wire logic [31:0] operand,
    output logic [4:0] m_count
);
    // m is the smallest m with operand < 2^(2m-1), capped at MAX_M; 0 and 1 give 1
    always_comb begin
        m_count = 5'(MAX_M);
        for (int k = MAX_M - 1; k >= 1; k--) begin
            if (operand < (33'h1 << (2 * k - 1))) begin
                m_count = 5'(k);
            end
        end
    end
endmodule : ict_mul_len

//--- core/ict_core_seq.sv
// instruction cycle sequencer: drives bus cycle class per clock
// assumes decoder presents class with instr_valid; coprocessor lines synchronous
// ---------------------------------------------------------------
// sequencer
// ---------------------------------------------------------------
module ict_core_seq #(
    parameter int ADDR_W = ict_pkg::ICT_ADDR_W
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic instr_valid,
    input wire ict_pkg::ict_class_t instr_class,
    input wire logic cond_pass,
    input wire logic [4:0] word_count,
    input wire logic [31:0] mul_operand,
    input wire logic [ADDR_W-1:0] alu_addr,
    input wire logic [ADDR_W-1:0] trap_vector_address,
    input wire logic coproc_absent_line,
    input wire logic coproc_busy_line,
    input wire logic addr_exception,
    input wire logic irq_req,
    input wire logic firq_req,
    input wire logic core_reset_req,
    output logic instr_ready,
    output logic [ADDR_W-1:0] bus_addr,
    output logic memory_request_n,
    output logic sequential_access,
    output logic opcode_fetch_n,
    output logic coproc_instr_offer_n,
    output logic write_n_read,
    output logic irq_pending,
    output logic firq_pending,
    output logic reset_pending,
    output logic [ADDR_W-1:0] pc_out
);
    typedef struct packed {
        ict_pkg::ict_state_t st;
        logic [ADDR_W-1:0] pc;
        logic [ADDR_W-1:0] addr;
        logic [ict_pkg::ICT_CNT_W-1:0] left;
        logic [ict_pkg::ICT_CNT_W-1:0] idx;
        ict_pkg::ict_class_t cls;
        logic [1:0] kind;
        logic opc_n;
        logic cpi_n;
        logic wr;
        logic irq;
        logic firq;
        logic rst;
    } ict_core_t;

    ict_core_t q;
    ict_core_t d;
    logic [4:0] m_count;

    ict_mul_len #(
        .MAX_M(ict_pkg::ICT_MUL_MAX)
    ) u_mul_len (
        .operand(mul_operand),
        .m_count(m_count)
    );

    // total cycles of one executed class, from word count n and multiply length m
    function automatic logic [ict_pkg::ICT_CNT_W-1:0] cyc_len(
        input ict_pkg::ict_class_t c,
        input logic [4:0] n,
        input logic [4:0] m
    );
        logic [ict_pkg::ICT_CNT_W-1:0] nn;
        nn = {1'b0, n};
        case (c)
            ict_pkg::ICT_DP: cyc_len = 6'h01;
            ict_pkg::ICT_DP_RS: cyc_len = 6'h02;
            ict_pkg::ICT_DP_PC: cyc_len = 6'h03;
            ict_pkg::ICT_LDR: cyc_len = 6'h03;
            ict_pkg::ICT_LDR_PC: cyc_len = 6'h05;
            ict_pkg::ICT_STR: cyc_len = 6'h02;
            ict_pkg::ICT_LDM: cyc_len = 6'(nn + 6'h02);
            ict_pkg::ICT_LDM_PC: cyc_len = 6'(nn + 6'h04);
            ict_pkg::ICT_STM: cyc_len = 6'(nn + 6'h01);
            ict_pkg::ICT_BRANCH: cyc_len = 6'h03;
            ict_pkg::ICT_SWI: cyc_len = 6'h03;
            ict_pkg::ICT_MUL: cyc_len = 6'({1'b0, m} + 6'h01);
            ict_pkg::ICT_CDP: cyc_len = 6'h01;
            ict_pkg::ICT_CPLS: cyc_len = 6'h03;
            ict_pkg::ICT_MCR: cyc_len = 6'h02;
            ict_pkg::ICT_MRC: cyc_len = 6'h03;
            default: cyc_len = 6'h01;
        endcase
    endfunction : cyc_len

    // kind of cycle i (0 first) within a class of length len
    function automatic ict_pkg::ict_cyc_t cyc_kind(
        input ict_pkg::ict_class_t c,
        input logic [ict_pkg::ICT_CNT_W-1:0] i,
        input logic [ict_pkg::ICT_CNT_W-1:0] len
    );
        logic last;
        last = (i == 6'(len - 6'h01));
        cyc_kind = ict_pkg::ICT_CYC_S;
        case (c)
            ict_pkg::ICT_DP_RS: if (i == 6'h00) cyc_kind = ict_pkg::ICT_CYC_I;
            ict_pkg::ICT_DP_PC, ict_pkg::ICT_BRANCH, ict_pkg::ICT_SWI: begin
                if (i == 6'h00) cyc_kind = ict_pkg::ICT_CYC_N;
            end
            ict_pkg::ICT_LDR: begin
                if (i == 6'h00) cyc_kind = ict_pkg::ICT_CYC_N;
                else if (i == 6'h01) cyc_kind = ict_pkg::ICT_CYC_I;
            end
            ict_pkg::ICT_LDR_PC: begin
                if (i <= 6'h01) cyc_kind = ict_pkg::ICT_CYC_N;
                else if (i == 6'h02) cyc_kind = ict_pkg::ICT_CYC_I;
            end
            ict_pkg::ICT_STR: cyc_kind = ict_pkg::ICT_CYC_N;
            ict_pkg::ICT_LDM: begin
                if (i == 6'h00) cyc_kind = ict_pkg::ICT_CYC_N;
                else if (last) cyc_kind = ict_pkg::ICT_CYC_I;
            end
            ict_pkg::ICT_LDM_PC: begin
                if (i == 6'h00 || i == 6'(len - 6'h02)) cyc_kind = ict_pkg::ICT_CYC_N;
                else if (i == 6'(len - 6'h03)) cyc_kind = ict_pkg::ICT_CYC_I;
            end
            ict_pkg::ICT_STM: begin
                if (i == 6'h00 || last) cyc_kind = ict_pkg::ICT_CYC_N;
            end
            ict_pkg::ICT_MUL: if (i != 6'h00) cyc_kind = ict_pkg::ICT_CYC_I;
            ict_pkg::ICT_CPLS: if (i != 6'h00) cyc_kind = ict_pkg::ICT_CYC_N;
            ict_pkg::ICT_MCR: if (last) cyc_kind = ict_pkg::ICT_CYC_C;
            ict_pkg::ICT_MRC: begin
                if (i == 6'h01) cyc_kind = ict_pkg::ICT_CYC_I;
                else if (last) cyc_kind = ict_pkg::ICT_CYC_C;
            end
            default: cyc_kind = ict_pkg::ICT_CYC_S;
        endcase
    endfunction : cyc_kind

    function automatic logic is_coproc(input ict_pkg::ict_class_t c);
        is_coproc = (c == ict_pkg::ICT_CDP) || (c == ict_pkg::ICT_CPLS) ||
            (c == ict_pkg::ICT_MCR) || (c == ict_pkg::ICT_MRC);
    endfunction : is_coproc

    function automatic logic is_store(input ict_pkg::ict_class_t c);
        is_store = (c == ict_pkg::ICT_STR) || (c == ict_pkg::ICT_STM);
    endfunction : is_store

    // drive one cycle of an instruction: kind and address
    function automatic ict_core_t put(
        input ict_core_t s,
        input ict_pkg::ict_cyc_t k,
        input logic [ADDR_W-1:0] alu
    );
        ict_core_t r;
        r = s;
        r.kind = k;
        // sequential addresses come from the incrementer, N addresses from the alu, I and C keep the address
        if (k == ict_pkg::ICT_CYC_N) r.addr = alu;
        else if (k == ict_pkg::ICT_CYC_S) r.addr = ADDR_W'(s.addr + ict_pkg::ICT_WORD_STEP);
        put = r;
    endfunction : put

    logic [ict_pkg::ICT_CNT_W-1:0] len;
    ict_pkg::ict_cyc_t k0;

    always_comb begin
        d = q;
        d.opc_n = 1'b1;
        d.cpi_n = 1'b1;
        d.wr = 1'b0;
        // requests captured every cycle and held until reset
        d.irq = q.irq | irq_req;
        d.firq = q.firq | firq_req;
        d.rst = q.rst | core_reset_req;
        len = cyc_len(instr_class, word_count, m_count);
        k0 = cyc_kind(instr_class, 6'h00, len);
        case (q.st)
            ict_pkg::ICT_ST_IDLE, ict_pkg::ICT_ST_EXEC, ict_pkg::ICT_ST_WAIT: begin
                if (q.st == ict_pkg::ICT_ST_WAIT && coproc_absent_line) begin
                    d.kind = ict_pkg::ICT_CYC_I;
                    d.st = ict_pkg::ICT_ST_UINT;
                end else if (q.st == ict_pkg::ICT_ST_WAIT && coproc_busy_line) begin
                    // busy-wait adds one internal cycle per busy sample
                    d.kind = ict_pkg::ICT_CYC_I;
                    d.cpi_n = 1'b0;
                end else if (q.st != ict_pkg::ICT_ST_IDLE && q.left != 6'h00) begin
                    d = put(d, cyc_kind(q.cls, q.idx, 6'(q.idx + q.left)), alu_addr);
                    d.wr = (q.st == ict_pkg::ICT_ST_WAIT) ? (q.cls == ict_pkg::ICT_MCR)
                        : (is_store(q.cls) && (q.idx != 6'h00));
                    d.st = ict_pkg::ICT_ST_EXEC;
                    d.idx = 6'(q.idx + 6'h01);
                    d.left = 6'(q.left - 6'h01);
                end else if (instr_valid) begin
                    d.pc = ADDR_W'(q.pc + ict_pkg::ICT_WORD_STEP);
                    d.cls = instr_class;
                    d.idx = 6'h01;
                    if (!cond_pass) begin
                        d.kind = ict_pkg::ICT_CYC_S;
                        d.addr = ADDR_W'(q.pc + ict_pkg::ICT_FETCH_AHEAD);
                        d.opc_n = 1'b0;
                        d.left = 6'h00;
                        d.st = ict_pkg::ICT_ST_EXEC;
                    end else if (instr_class == ict_pkg::ICT_UNDEF) begin
                        d.kind = ict_pkg::ICT_CYC_I;
                        d.addr = ADDR_W'(q.pc + ict_pkg::ICT_FETCH_AHEAD);
                        d.opc_n = 1'b0;
                        d.cpi_n = 1'b0;
                        d.st = ict_pkg::ICT_ST_OFFER;
                    end else begin
                        d.kind = k0;
                        d.addr = ADDR_W'(q.pc + ict_pkg::ICT_FETCH_AHEAD);
                        d.opc_n = 1'b0;
                        d.cpi_n = !is_coproc(instr_class);
                        d.left = 6'(len - 6'h01);
                        d.st = is_coproc(instr_class) ? ict_pkg::ICT_ST_WAIT
                                                      : ict_pkg::ICT_ST_EXEC;
                    end
                end else begin
                    d.kind = ict_pkg::ICT_CYC_I;
                    d.st = ict_pkg::ICT_ST_IDLE;
                end
            end
            ict_pkg::ICT_ST_OFFER: begin
                if (coproc_absent_line) begin
                    d.kind = ict_pkg::ICT_CYC_N;
                    d.opc_n = 1'b0;
                    d.st = ict_pkg::ICT_ST_VEC0;
                end else begin
                    d.kind = ict_pkg::ICT_CYC_I;
                    d.cpi_n = 1'b0;
                end
            end
            ict_pkg::ICT_ST_UINT: begin
                d.kind = ict_pkg::ICT_CYC_N;
                d.opc_n = 1'b0;
                d.st = ict_pkg::ICT_ST_VEC0;
            end
            ict_pkg::ICT_ST_VEC0: begin
                d.kind = ict_pkg::ICT_CYC_S;
                d.addr = trap_vector_address;
                d.opc_n = 1'b0;
                d.st = ict_pkg::ICT_ST_VEC1;
            end
            ict_pkg::ICT_ST_VEC1: begin
                d.kind = ict_pkg::ICT_CYC_S;
                d.addr = ADDR_W'(trap_vector_address + ict_pkg::ICT_WORD_STEP);
                d.opc_n = 1'b0;
                d.pc = trap_vector_address;
                d.st = ict_pkg::ICT_ST_IDLE;
            end
            default: d.st = ict_pkg::ICT_ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            q <= '0;
            q.st <= ict_pkg::ICT_ST_IDLE;
            q.pc <= ict_pkg::ICT_RESET_PC;
            q.kind <= ict_pkg::ICT_CYC_I;
            q.opc_n <= 1'b1;
            q.cpi_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    // internal cycles are assumed to cost one clock at the memory side
    // a coprocessor op with no busy sample left ends at once, so b=0 adds no cycle
    assign instr_ready = (q.st == ict_pkg::ICT_ST_IDLE) ||
        (q.st == ict_pkg::ICT_ST_EXEC && q.left == 6'h00) ||
        (q.st == ict_pkg::ICT_ST_WAIT && !coproc_absent_line && !coproc_busy_line &&
        q.left == 6'h00);
    assign bus_addr = q.addr;
    assign memory_request_n = q.kind[1];
    assign sequential_access = q.kind[0];
    assign opcode_fetch_n = q.opc_n;
    assign coproc_instr_offer_n = q.cpi_n;
    // exception on a store turns the cycle into a read, same cycle
    assign write_n_read = q.wr & ~addr_exception;
    assign irq_pending = q.irq;
    assign firq_pending = q.firq;
    assign reset_pending = q.rst;
    assign pc_out = q.pc;
endmodule : ict_core_seq

//--- tb/ict_core_seq_chk.sv
// checker: bus cycle class and latch relations of the sequencer
// assumes it is bound onto ict_core_seq, one clock domain
module ict_core_seq_chk #(
    parameter int ADDR_W = 26
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic instr_valid,
    input wire ict_pkg::ict_class_t instr_class,
    input wire logic cond_pass,
    input wire logic [ADDR_W-1:0] alu_addr,
    input wire logic [ADDR_W-1:0] trap_vector_address,
    input wire logic coproc_absent_line,
    input wire logic addr_exception,
    input wire logic irq_req,
    input wire logic firq_req,
    input wire logic core_reset_req,
    input wire logic instr_ready,
    input wire logic [ADDR_W-1:0] bus_addr,
    input wire logic memory_request_n,
    input wire logic sequential_access,
    input wire logic opcode_fetch_n,
    input wire logic coproc_instr_offer_n,
    input wire logic write_n_read,
    input wire logic irq_pending,
    input wire logic firq_pending,
    input wire logic reset_pending
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------
    // helpers
    // ------
    logic is_s;
    logic is_n;
    logic is_i;
    logic take;
    assign is_s = {memory_request_n, sequential_access} == ict_pkg::ICT_CYC_S;
    assign is_n = {memory_request_n, sequential_access} == ict_pkg::ICT_CYC_N;
    assign is_i = {memory_request_n, sequential_access} == ict_pkg::ICT_CYC_I;
    assign take = instr_valid && instr_ready && cond_pass;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);
    // ------
    // properties
    // ------
    property p_rst;
        disable iff (1'b0) reset |=> memory_request_n && !sequential_access
            && opcode_fetch_n && coproc_instr_offer_n && !irq_pending && !reset_pending;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    property p_cf;
        instr_valid && instr_ready && !cond_pass |=> is_s && !opcode_fetch_n && instr_ready;
    endproperty
    a_cf: assert property (p_cf) else $error("failed condition not one S");
    property p_dp;
        take && instr_class == ict_pkg::ICT_DP |=> is_s && instr_ready;
    endproperty
    a_dp: assert property (p_dp) else $error("plain op not one S");
    property p_ldr;
        take && instr_class == ict_pkg::ICT_LDR |=> is_n ##1 is_i ##1 (is_s && instr_ready);
    endproperty
    a_ldr: assert property (p_ldr) else $error("load not N I S");
    property p_trap;
        !coproc_instr_offer_n && coproc_absent_line |=> is_n
            ##1 (is_s && bus_addr == trap_vector_address)
            ##1 (is_s && bus_addr == trap_vector_address + ict_pkg::ICT_WORD_STEP);
    endproperty
    a_trap: assert property (p_trap) else $error("trap sequence wrong");
    property p_exc;
        addr_exception |-> !write_n_read;
    endproperty
    a_exc: assert property (p_exc) else $error("write during exception");
    property p_nd;
        is_n && opcode_fetch_n |-> bus_addr == alu_addr;
    endproperty
    a_nd: assert property (p_nd) else $error("data N address wrong");
    property p_off;
        $fell(coproc_instr_offer_n) |-> !opcode_fetch_n;
    endproperty
    a_off: assert property (p_off) else $error("offer without fetch");
    property p_lat;
        irq_req |=> irq_pending ##1 irq_pending;
    endproperty
    a_lat: assert property (p_lat) else $error("irq not latched");
    property p_lat2;
        firq_req && core_reset_req |=> firq_pending && reset_pending;
    endproperty
    a_lat2: assert property (p_lat2) else $error("firq or reset not latched");
endmodule : ict_core_seq_chk

bind ict_core_seq ict_core_seq_chk #(.ADDR_W(ADDR_W)) u_chk (
    .sys_clk(sys_clk), .reset(reset), .instr_valid(instr_valid),
    .instr_class(instr_class), .cond_pass(cond_pass), .alu_addr(alu_addr),
    .trap_vector_address(trap_vector_address), .coproc_absent_line(coproc_absent_line),
    .addr_exception(addr_exception), .irq_req(irq_req), .firq_req(firq_req),
    .core_reset_req(core_reset_req), .instr_ready(instr_ready), .bus_addr(bus_addr),
    .memory_request_n(memory_request_n), .sequential_access(sequential_access),
    .opcode_fetch_n(opcode_fetch_n), .coproc_instr_offer_n(coproc_instr_offer_n),
    .write_n_read(write_n_read), .irq_pending(irq_pending),
    .firq_pending(firq_pending), .reset_pending(reset_pending));

//--- tb/ict_cp_model.sv
// coprocessor stand-in driving the absent and busy handshake lines
// assumes the offer strobe is registered by the sequencer
module ict_cp_model (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic coproc_instr_offer_n,
    input wire logic present,
    input wire logic [4:0] busy_cycles,
    output logic coproc_absent_line,
    output logic coproc_busy_line
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] used_q;
    logic drive;
    assign drive = present && !coproc_instr_offer_n;
    always_ff @(posedge sys_clk) begin
        if (reset || coproc_instr_offer_n) begin
            used_q <= 5'h00;
        end else if (used_q != 5'h1F) begin
            used_q <= used_q + 5'h01;
        end
    end
    // lines left undriven float high, read as absent
    assign coproc_absent_line = drive ? 1'b0 : 1'b1;
    // busy for the first b samples of an offer
    assign coproc_busy_line = drive ? (used_q < busy_cycles) : 1'b1;
endmodule : ict_cp_model

//--- tb/instruction_cycle_timing_tb.sv
// bench for the sequencer: cycle counts per class, traps, latches
// assumes the coprocessor stand-in and the bound checker
module instruction_cycle_timing_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic [4:0] c;
        logic cp;
        logic [4:0] n;
        logic [31:0] mo;
        logic [4:0] b;
        int s;
        int nn;
        int i;
        int k;
    } ict_row_t;
    localparam logic [25:0] TV = 26'h0000100;
    logic sys_clk, reset, instr_valid, cond_pass, addr_exception, present;
    logic irq_req, firq_req, core_reset_req, coproc_absent_line, coproc_busy_line;
    logic instr_ready, memory_request_n, sequential_access, opcode_fetch_n;
    logic coproc_instr_offer_n, write_n_read, irq_pending, firq_pending, reset_pending;
    ict_pkg::ict_class_t instr_class;
    logic [4:0] word_count, busy_cycles;
    logic [31:0] mul_operand;
    logic [25:0] alu_addr, trap_vector_address, bus_addr, pc_out;
    logic [25:0] s_addr[$];
    int mismatches = 0;
    int cmp_count = 0;
    int cyc = 0;
    int s, nn, i, k, wr;
    ict_row_t rows [26];

    ict_core_seq DUT (
        .sys_clk(sys_clk), .reset(reset), .instr_valid(instr_valid),
        .instr_class(instr_class), .cond_pass(cond_pass), .word_count(word_count),
        .mul_operand(mul_operand), .alu_addr(alu_addr),
        .trap_vector_address(trap_vector_address), .coproc_absent_line(coproc_absent_line),
        .coproc_busy_line(coproc_busy_line), .addr_exception(addr_exception),
        .irq_req(irq_req), .firq_req(firq_req), .core_reset_req(core_reset_req),
        .instr_ready(instr_ready), .bus_addr(bus_addr), .memory_request_n(memory_request_n),
        .sequential_access(sequential_access), .opcode_fetch_n(opcode_fetch_n),
        .coproc_instr_offer_n(coproc_instr_offer_n), .write_n_read(write_n_read),
        .irq_pending(irq_pending), .firq_pending(firq_pending),
        .reset_pending(reset_pending), .pc_out(pc_out));
    ict_cp_model u_cp (
        .sys_clk(sys_clk), .reset(reset), .coproc_instr_offer_n(coproc_instr_offer_n),
        .present(present), .busy_cycles(busy_cycles),
        .coproc_absent_line(coproc_absent_line), .coproc_busy_line(coproc_busy_line));

    // ------
    // tasks
    // ------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic results();
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : results
    task automatic tick();
        @(posedge sys_clk);
        #1;
    endtask : tick
    // offers one instruction and tallies cycle kinds until ready returns
    task automatic run(input ict_row_t r);
        int t;
        // one idle edge lets the offer strobe rise, so the stand-in sees a new offer
        tick();
        for (t = 0; t < 50 && instr_ready !== 1'b1; t++) begin
            tick();
        end
        instr_class = ict_pkg::ict_class_t'(r.c);
        cond_pass = r.cp;
        word_count = r.n;
        mul_operand = r.mo;
        busy_cycles = r.b;
        present = r.c inside {[5'h0C:5'h0F]};
        instr_valid = 1'b1;
        tick();
        instr_valid = 1'b0;
        {s, nn, i, k, wr} = '0;
        s_addr.delete();
        for (t = 0; t < 40; t++) begin
            case ({memory_request_n, sequential_access})
                2'h0: nn++;
                2'h1: begin
                    s++;
                    s_addr.push_back(bus_addr);
                end
                2'h2: i++; // one clock per internal cycle
                2'h3: k++;
                default: k += 100;
            endcase
            if (write_n_read === 1'b1) begin
                wr = 1;
            end
            if (instr_ready === 1'b1) begin
                break;
            end
            tick();
        end
    endtask : run

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 2000) begin
            mismatches++;
            results();
        end
    end

    initial begin
        rows = '{'{5'h00, 1, 5'h01, 32'h0, 5'h00, 1, 0, 0, 0},
            '{5'h01, 1, 5'h01, 32'h0, 5'h00, 1, 0, 1, 0},
            '{5'h02, 1, 5'h01, 32'h0, 5'h00, 2, 1, 0, 0},
            '{5'h03, 1, 5'h01, 32'h0, 5'h00, 1, 1, 1, 0},
            '{5'h04, 1, 5'h01, 32'h0, 5'h00, 2, 2, 1, 0},
            '{5'h05, 1, 5'h01, 32'h0, 5'h00, 0, 2, 0, 0},
            '{5'h06, 1, 5'h03, 32'h0, 5'h00, 3, 1, 1, 0},
            '{5'h07, 1, 5'h03, 32'h0, 5'h00, 4, 2, 1, 0},
            '{5'h08, 1, 5'h01, 32'h0, 5'h00, 0, 2, 0, 0},
            '{5'h08, 1, 5'h03, 32'h0, 5'h00, 2, 2, 0, 0},
            '{5'h09, 1, 5'h01, 32'h0, 5'h00, 2, 1, 0, 0},
            '{5'h0A, 1, 5'h01, 32'h0, 5'h00, 2, 1, 0, 0},
            '{5'h0B, 1, 5'h01, 32'h0, 5'h00, 1, 0, 1, 0},
            '{5'h0B, 1, 5'h01, 32'h2, 5'h00, 1, 0, 2, 0},
            '{5'h0B, 1, 5'h01, 32'h7, 5'h00, 1, 0, 2, 0},
            '{5'h0B, 1, 5'h01, 32'h8, 5'h00, 1, 0, 3, 0},
            '{5'h0B, 1, 5'h01, 32'h1FFFFFFF, 5'h00, 1, 0, 15, 0},
            '{5'h0B, 1, 5'h01, 32'hFFFFFFFF, 5'h00, 1, 0, 16, 0},
            '{5'h0C, 1, 5'h01, 32'h0, 5'h00, 1, 0, 0, 0},
            '{5'h0C, 1, 5'h01, 32'h0, 5'h02, 1, 0, 2, 0},
            '{5'h0D, 1, 5'h01, 32'h0, 5'h01, 1, 2, 1, 0},
            '{5'h0E, 1, 5'h01, 32'h0, 5'h01, 1, 0, 1, 1},
            '{5'h0F, 1, 5'h01, 32'h0, 5'h02, 1, 0, 3, 1},
            '{5'h10, 1, 5'h01, 32'h0, 5'h00, 2, 1, 1, 0},
            '{5'h03, 0, 5'h01, 32'h0, 5'h00, 1, 0, 0, 0},
            '{5'h0B, 0, 5'h01, 32'h8, 5'h00, 1, 0, 0, 0}};
        {reset, instr_valid, cond_pass, addr_exception, present} = 5'h10;
        {irq_req, firq_req, core_reset_req} = 3'h0;
        instr_class = ict_pkg::ICT_DP;
        {word_count, busy_cycles, mul_operand} = {5'h01, 5'h00, 32'h0};
        alu_addr = 26'h0002000;
        trap_vector_address = TV;
        repeat (5) @(posedge sys_clk);
        #1;
        reset = 1'b0;
        check({memory_request_n, sequential_access, opcode_fetch_n}, 3'h5);
        check(32'(bus_addr), 32'h0);
        check(32'(pc_out), 32'h0);
        check({irq_pending, firq_pending, reset_pending}, 3'h0);
        $display("reset test done");
        foreach (rows[r]) begin
            run(rows[r]);
            check(s, rows[r].s);
            check(nn, rows[r].nn);
            check(i, rows[r].i);
            check(k, rows[r].k);
            if (rows[r].c == 5'h10) begin
                check(s_addr[0], TV);
                check(s_addr[1], TV + 26'h0000004);
            end
            $display("row %0d done", r);
        end
        addr_exception = 1'b1;
        run(rows[5]);
        check(wr, 0);
        addr_exception = 1'b0;
        run(rows[5]);
        check(wr, 1);
        $display("store test done");
        {irq_req, firq_req, core_reset_req} = 3'h7;
        tick();
        {irq_req, firq_req, core_reset_req} = 3'h0;
        tick();
        check({irq_pending, firq_pending, reset_pending}, 3'h7);
        reset = 1'b1;
        tick();
        reset = 1'b0;
        check({irq_pending, firq_pending, reset_pending}, 3'h0);
        check({memory_request_n, sequential_access, coproc_instr_offer_n}, 3'h5);
        $display("latch and reset test done");
        results();
    end
endmodule : instruction_cycle_timing_tb
